// ===== logic/lookup_pkg.sv
// Package with widths, reset values and state codes of the lookup executor.
package lookup_pkg;
    localparam int PC_LOW_W    = 7;
    localparam int PC_HIGH_W   = 4;
    localparam int PC_W        = PC_LOW_W + PC_HIGH_W;
    localparam int ACC_W       = 4;
    localparam int D_W         = 3;
    localparam int ROM_W       = 8;
    localparam int SP_W        = 3;
    localparam int STACK_DEPTH = 8;
    localparam int NIB_HI_MSB  = 7;
    localparam int NIB_HI_LSB  = 4;
    localparam int NIB_LO_MSB  = 3;
    localparam int NIB_LO_LSB  = 0;
    localparam logic [SP_W-1:0]    SP_ONE      = 3'h1;
    localparam logic [SP_W-1:0]    SP_RESET    = 3'h7;
    localparam logic [PC_W-1:0]    PC_RESET    = 11'h000;
    localparam logic [ACC_W-1:0]   ACC_RESET   = 4'h0;
    localparam logic [PC_HIGH_W-1:0] PAGE_MAX_SMALL = 4'h3;
    localparam logic [PC_HIGH_W-1:0] PAGE_MAX_LARGE = 4'hf;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_PUSH  = 4'h2,
        ST_FETCH = 4'h4,
        ST_POP   = 4'h8
    } lookup_state_type;
endpackage

// ===== logic/stack_if.sv
// Interface carrying push and pop requests between executor and stack.
`timescale 1ns/100ps
interface stack_if;
    import lookup_pkg::*;
    logic                push;
    logic                pop;
    logic [PC_W-1:0]     push_data;
    logic [PC_W-1:0]     top_data;
    logic [SP_W-1:0]     pointer;
    modport master (output push, output pop, output push_data,
                    input top_data, input pointer);
    modport slave  (input push, input pop, input push_data,
                    output top_data, output pointer);
endinterface

// ===== logic/return_stack.sv
// Program counter stack with its pointer.
`timescale 1ns/100ps
module return_stack
    import lookup_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    stack_if.slave    stk
);
    logic [PC_W-1:0] entry_r [STACK_DEPTH];
    logic [SP_W-1:0] stack_pointer_r;

    function automatic logic [SP_W-1:0] sp_after_push(
        input logic [SP_W-1:0] sp);
        return sp + SP_ONE;
    endfunction

    // Increment first, then store into the entry the new pointer selects.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            stack_pointer_r <= SP_RESET;
        end else if (stk.push) begin
            stack_pointer_r <= sp_after_push(stack_pointer_r);
        end else if (stk.pop) begin
            stack_pointer_r <= stack_pointer_r - SP_ONE;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (stk.push) begin
            entry_r[sp_after_push(stack_pointer_r)] <= stk.push_data;
        end
    end

    assign stk.top_data = entry_r[stack_pointer_r];
    assign stk.pointer  = stack_pointer_r;

    AST_PUSH_INC: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        stk.push |=> stack_pointer_r == $past(stack_pointer_r) + SP_ONE)
        else $error("Stack pointer did not step up on push.");
    AST_POP_DEC: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        stk.pop && !stk.push |=>
            stack_pointer_r == $past(stack_pointer_r) - SP_ONE)
        else $error("Stack pointer did not step down on pop.");
endmodule

// ===== logic/table_lookup_exec.sv
// Executor for the paged table lookup and the D to accumulator move.
`timescale 1ns/100ps
module table_lookup_exec
    import lookup_pkg::*;
#(
    parameter bit LARGE_PAGES = 1'b1
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  table_lookup_paged_in,
    input  wire logic                  move_d_to_accumulator_in,
    input  wire logic [PC_HIGH_W-1:0]  page_in,
    input  wire logic [PC_W-1:0]       pc_in,
    input  wire logic                  d_load_in,
    input  wire logic [D_W-1:0]        d_value_in,
    input  wire logic                  acc_load_in,
    input  wire logic [ACC_W-1:0]      acc_value_in,
    input  wire logic [ROM_W-1:0]      rom_data_in,
    output logic [PC_W-1:0]            rom_addr_out,
    output logic [PC_W-1:0]            pc_out,
    output logic                       pc_valid_out,
    output logic [ACC_W-1:0]           acc_out,
    output logic [ACC_W-1:0]           reg_b_out,
    output logic [D_W-1:0]             reg_d_out,
    output logic [SP_W-1:0]            stack_pointer_out,
    output logic                       busy_out
);
    lookup_state_type state_r;
    logic [PC_W-1:0]  pc_r;
    logic             pc_valid_r;
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] reg_b_r;
    logic [D_W-1:0]   reg_d_r;
    logic [PC_HIGH_W-1:0] page_r;
    logic                 idle_free;
    stack_if          stk ();

    return_stack u_stack (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .stk        (stk)
    );

    function automatic logic [PC_HIGH_W-1:0] page_limit(
        input logic [PC_HIGH_W-1:0] p);
        logic [PC_HIGH_W-1:0] lim;
        lim = LARGE_PAGES ? PAGE_MAX_LARGE : PAGE_MAX_SMALL;
        return (p > lim) ? lim : p;
    endfunction

    function automatic logic [PC_W-1:0] lookup_addr(
        input logic [PC_HIGH_W-1:0] p, input logic [D_W-1:0] d,
        input logic [ACC_W-1:0] a);
        return {p, d, a};
    endfunction

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE:  if (table_lookup_paged_in) state_r <= ST_PUSH;
                ST_PUSH:  state_r <= ST_FETCH;
                ST_FETCH: state_r <= ST_POP;
                ST_POP:   state_r <= ST_IDLE;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    // The operand is trimmed to the pages that exist on this variant.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            page_r <= '0;
        end else if (state_r == ST_IDLE && table_lookup_paged_in) begin
            page_r <= page_limit(page_in);
        end
    end

    assign stk.push      = (state_r == ST_PUSH);
    assign stk.pop       = (state_r == ST_POP);
    assign stk.push_data = pc_r;

    // Register writes yield to a lookup that starts on the same edge.
    assign idle_free = (state_r == ST_IDLE) && !table_lookup_paged_in;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pc_r       <= PC_RESET;
            pc_valid_r <= 1'b0;
        end else begin
            pc_valid_r <= 1'b0;
            case (state_r)
                ST_IDLE: if (table_lookup_paged_in) pc_r <= pc_in;
                ST_PUSH: begin
                    pc_r <= lookup_addr(page_r, reg_d_r, acc_r);
                end
                ST_POP: begin
                    pc_r       <= stk.top_data;
                    pc_valid_r <= 1'b1;
                end
                default: pc_r <= pc_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            acc_r   <= ACC_RESET;
            reg_b_r <= ACC_RESET;
        end else if (state_r == ST_FETCH) begin
            reg_b_r <= rom_data_in[NIB_HI_MSB:NIB_HI_LSB];
            acc_r   <= rom_data_in[NIB_LO_MSB:NIB_LO_LSB];
        end else if (idle_free && move_d_to_accumulator_in) begin
            acc_r <= {1'b0, reg_d_r};
        end else if (idle_free && acc_load_in) begin
            acc_r <= acc_value_in;
        end
    end

    // D is only written from outside while idle; a lookup never writes it.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_d_r <= '0;
        end else if (idle_free && d_load_in) begin
            reg_d_r <= d_value_in;
        end
    end

    assign rom_addr_out      = pc_r;
    assign pc_out            = pc_r;
    assign pc_valid_out      = pc_valid_r;
    assign acc_out           = acc_r;
    assign reg_b_out         = reg_b_r;
    assign reg_d_out         = reg_d_r;
    assign stack_pointer_out = stk.pointer;
    assign busy_out          = (state_r != ST_IDLE);

    sequence lookup_start_s;
        state_r == ST_IDLE && table_lookup_paged_in;
    endsequence
    sequence lookup_run_s;
        ##1 state_r == ST_PUSH ##1 state_r == ST_FETCH ##1 state_r == ST_POP;
    endsequence

    AST_SEQUENCE: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in) lookup_start_s |-> lookup_run_s)
        else $error("Lookup did not walk push, fetch, pop.");
    AST_ADDR: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state_r == ST_FETCH |->
            rom_addr_out == {page_r, reg_d_r, $past(acc_r)})
        else $error("Lookup address wrong.");
    AST_NIBBLES: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state_r == ST_FETCH |=>
            reg_b_out == $past(rom_data_in[NIB_HI_MSB:NIB_HI_LSB])
            && acc_out == $past(rom_data_in[NIB_LO_MSB:NIB_LO_LSB]))
        else $error("ROM nibbles not split into B and accumulator.");
    AST_RETURN: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        lookup_start_s |-> ##4 pc_out == $past(pc_in, 4) && pc_valid_out)
        else $error("Program counter not restored after lookup.");
    AST_SP_BALANCE: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        lookup_start_s |->
            ##4 stack_pointer_out == $past(stack_pointer_out, 4))
        else $error("Stack pointer unbalanced after lookup.");
    AST_PAGE: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        busy_out |-> page_r <= (LARGE_PAGES ? PAGE_MAX_LARGE : PAGE_MAX_SMALL))
        else $error("Page operand out of range.");
    AST_D_MOVE: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state_r == ST_IDLE && move_d_to_accumulator_in
            && !table_lookup_paged_in
            |=> acc_out == {1'b0, $past(reg_d_r)})
        else $error("D move to accumulator wrong.");
    AST_D_KEEP: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        busy_out |=> $stable(reg_d_out))
        else $error("Register D changed during lookup.");

    // A start edge must not let a competing write spoil the lookup address.
    AST_START_HOLD: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        lookup_start_s |=> $stable(acc_r))
        else $error("Accumulator changed on lookup start.");
    AST_D_START: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        lookup_start_s |=> $stable(reg_d_r))
        else $error("Register D changed on lookup start.");
    AST_PUSH_SAVE: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        stk.push |=> stk.top_data == $past(stk.push_data))
        else $error("Program counter not saved on push.");
    AST_PC_HIGH: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state_r == ST_FETCH |-> pc_r[PC_W-1:PC_LOW_W] == page_r)
        else $error("Program counter high part is not the page.");
    AST_PC_LOW: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state_r == ST_FETCH |->
            pc_r[PC_LOW_W-1:0] == {reg_d_r, acc_r})
        else $error("Program counter low part is not D and accumulator.");
    AST_MOVE_TOP: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state_r == ST_IDLE && move_d_to_accumulator_in
            && !table_lookup_paged_in |=> !acc_out[ACC_W-1])
        else $error("Accumulator top bit not cleared by D move.");
    AST_VALID_PULSE: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        pc_valid_out |=> !pc_valid_out)
        else $error("Restore strobe longer than one cycle.");
    AST_BUSY_SPAN: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        lookup_start_s |=> busy_out[*3] ##1 !busy_out)
        else $error("Lookup did not last three busy cycles.");
endmodule

// ===== sim/table_lookup_and_d_transfer_exec_bench.sv
// Self-checking bench for the paged table lookup and the D move.
`timescale 1ns/100ps
module table_lookup_and_d_transfer_exec_bench;
    import lookup_pkg::*;
    logic                 ref_clk_in = 1'b0;
    logic                 sys_rst_in = 1'b1;
    logic                 start_in = 1'b0;
    logic                 move_in = 1'b0;
    logic [PC_HIGH_W-1:0] page_in = 4'h0;
    logic [PC_W-1:0]      pc_in = 11'h000;
    logic                 d_load_in = 1'b0;
    logic [D_W-1:0]       d_value_in = 3'h0;
    logic                 acc_load_in = 1'b0;
    logic [ACC_W-1:0]     acc_value_in = 4'h0;
    logic [ROM_W-1:0]     rom_data_in;
    logic [PC_W-1:0]      rom_addr_out, pc_out;
    logic                 pc_valid_out, busy_out;
    logic [ACC_W-1:0]     acc_out, reg_b_out;
    logic [D_W-1:0]       reg_d_out;
    logic [SP_W-1:0]      stack_pointer_out;
    logic [PC_W-1:0]      small_rom_addr;
    logic [ROM_W-1:0]     small_rom_data;
    logic [ACC_W-1:0]     small_reg_b;
    int                   mismatches = 0;
    int                   samples_checked = 0;

    table_lookup_exec #(.LARGE_PAGES(1'b1)) uut (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .table_lookup_paged_in(start_in),
        .move_d_to_accumulator_in(move_in),
        .page_in(page_in), .pc_in(pc_in),
        .d_load_in(d_load_in), .d_value_in(d_value_in),
        .acc_load_in(acc_load_in), .acc_value_in(acc_value_in),
        .rom_data_in(rom_data_in), .rom_addr_out(rom_addr_out),
        .pc_out(pc_out), .pc_valid_out(pc_valid_out),
        .acc_out(acc_out), .reg_b_out(reg_b_out),
        .reg_d_out(reg_d_out), .stack_pointer_out(stack_pointer_out),
        .busy_out(busy_out));

    // Bench ROM: every address gives an address-dependent byte; 2048 addresses share 256 byte values.
    function automatic logic [ROM_W-1:0] rom_pattern(logic [PC_W-1:0] a);
        return a[7:0] ^ {1'b0, a[10:4]} ^ 8'h5a;
    endfunction
    assign rom_data_in = rom_pattern(rom_addr_out);

    // Small-page variant runs the same stimulus to exercise the page clamp.
    table_lookup_exec #(.LARGE_PAGES(1'b0)) uut_small (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .table_lookup_paged_in(start_in),
        .move_d_to_accumulator_in(move_in),
        .page_in(page_in), .pc_in(pc_in),
        .d_load_in(d_load_in), .d_value_in(d_value_in),
        .acc_load_in(acc_load_in), .acc_value_in(acc_value_in),
        .rom_data_in(small_rom_data), .rom_addr_out(small_rom_addr),
        .pc_out(), .pc_valid_out(),
        .acc_out(), .reg_b_out(small_reg_b),
        .reg_d_out(), .stack_pointer_out(),
        .busy_out());
    assign small_rom_data = rom_pattern(small_rom_addr);

    always #10 ref_clk_in = ~ref_clk_in;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge ref_clk_in);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("mismatches=%0d samples_checked=%0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic load_regs(input logic [2:0] d, input logic [3:0] a);
        d_load_in = 1'b1;
        d_value_in = d;
        acc_load_in = 1'b1;
        acc_value_in = a;
        tick();
        d_load_in = 1'b0;
        acc_load_in = 1'b0;
    endtask

    task automatic test_reset();
        check(stack_pointer_out, SP_RESET);
        check({pc_valid_out, busy_out, pc_out}, 13'h0000);
        check({acc_out, reg_b_out, reg_d_out}, 11'h000);
    endtask

    // Lookup with a competing D move and refused writes while busy.
    task automatic test_lookup(input logic [3:0] p, input logic [2:0] d,
                               input logic [3:0] a, input logic [10:0] pc);
        logic [PC_W-1:0]      addr;
        logic [PC_W-1:0]      addr_small;
        logic [PC_HIGH_W-1:0] p_small;
        logic [SP_W-1:0]      sp0;
        logic [SP_W-1:0]      sp1;
        load_regs(d, a);
        addr = {p, d, a};
        p_small = (p > PAGE_MAX_SMALL) ? PAGE_MAX_SMALL : p;
        addr_small = {p_small, d, a};
        sp0 = stack_pointer_out;
        sp1 = sp0 + SP_ONE;
        start_in = 1'b1;
        move_in = 1'b1;
        page_in = p;
        pc_in = pc;
        tick();
        start_in = 1'b0;
        page_in = ~p;
        pc_in = ~pc;
        check(busy_out, 1'b1);
        d_load_in = 1'b1;
        d_value_in = ~d;
        acc_load_in = 1'b1;
        acc_value_in = ~a;
        tick();
        check(rom_addr_out, addr);
        check(small_rom_addr, addr_small);
        check(stack_pointer_out, sp1);
        tick();
        move_in = 1'b0;
        d_load_in = 1'b0;
        acc_load_in = 1'b0;
        check(reg_b_out, rom_pattern(addr) >> 4);
        check(acc_out, rom_pattern(addr) & 8'h0f);
        check(small_reg_b, rom_pattern(addr_small) >> 4);
        tick();
        check({pc_valid_out, busy_out}, 2'b10);
        check(pc_out, pc);
        check(stack_pointer_out, sp0);
        check(reg_d_out, d);
        check(acc_out, rom_pattern(addr) & 8'h0f);
        tick();
        check(pc_valid_out, 1'b0);
    endtask

    task automatic test_move_d();
        load_regs(3'h7, 4'h9);
        tick();
        move_in = 1'b1;
        acc_load_in = 1'b1;
        acc_value_in = 4'h6;
        tick();
        move_in = 1'b0;
        acc_load_in = 1'b0;
        check(acc_out, 4'h7);
        check(reg_d_out, 3'h7);
        tick();
        load_regs(3'h2, 4'hf);
        move_in = 1'b1;
        tick();
        move_in = 1'b0;
        check(acc_out, 4'h2);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_in);
        #1;
        test_reset();
        sys_rst_in = 1'b0;
        tick();
        test_lookup(4'h0, 3'h5, 4'ha, 11'h123);
        test_lookup(4'hf, 3'h7, 4'hf, 11'h7fe);
        test_lookup(4'h9, 3'h0, 4'h1, 11'h000);
        test_move_d();
        sys_rst_in = 1'b1;
        tick();
        test_reset();
        tally_and_finish();
    end

    initial begin
        #(20 * 500);
        mismatches++;
        tally_and_finish();
    end
endmodule
